// *** hdl/selftest_top.sv ***
// Loopback selection and PRBS self-test of the PHY, with its receive FIFO.
// Assumes MAC, line and register port on core_clk; mode pins are async.
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Receive FIFO
// ****************************************
module byte_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                full;
    } fifo_t;
    fifo_t f_q, f_d;
    logic  push, pop;

    assign push      = in_valid & ~f_q.full;
    assign pop       = out_valid & out_ready;
    assign in_ready  = ~f_q.full;
    assign out_valid = f_q.cnt != '0;
    assign out_data  = f_q.mem[f_q.rp];

    always_comb begin
        f_d = f_q;
        if (push) begin
            f_d.mem[f_q.wp] = in_data;
            f_d.wp          = AW'(f_q.wp + 1'b1);
        end
        if (pop) begin
            f_d.rp = AW'(f_q.rp + 1'b1);
        end
        f_d.cnt  = (AW+1)'(f_q.cnt + push - pop);
        f_d.full = f_d.cnt == (AW+1)'(D);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end
endmodule : byte_fifo

// ****************************************
// Loopback and self-test top
// ****************************************
module selftest_top (
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    input  wire selftest_pkg::op_mode_t op_mode,
    input  wire selftest_pkg::speed_t   speed,
    input  wire logic                   line_link,
    input  wire selftest_pkg::stream_t  mac_tx,
    output logic                        mac_tx_ready,
    output selftest_pkg::stream_t       mac_rx,
    input  wire logic                   mac_rx_ready,
    input  wire selftest_pkg::stream_t  line_rx,
    output logic                        line_rx_ready,
    output selftest_pkg::stream_t       line_tx,
    output logic                        link_up,
    input  wire selftest_pkg::reg_req_t reg_req,
    output logic [15:0]                 reg_rdata,
    output logic                        reg_rvalid
);
    import selftest_pkg::*;

    typedef struct packed {
        op_mode_t    op1, op2;
        speed_t      spd1, spd2;
        logic        lnk1, lnk2;
        logic [15:0] bc, phy, st, pcfg, lsetup;
        logic [15:0] rdata;
        logic        rvalid;
        gen_state_t  gst;
        logic [14:0] glfsr;
        logic [7:0]  gcnt;
        logic [14:0] hist;
        logic        locked, lost, chk_d, prev_v;
        logic [1:0]  run;
        logic [7:0]  err, l_err;
        logic [15:0] bytes, l_bytes;
        logic [31:0] pkts, l_pkts;
        stream_t     ltx, mrx;
        logic        link;
    } state_t;

    localparam state_t S_RST = '{bc: RST_CTRL, pcfg: RST_PCFG, gst: GEN_IDLE,
                                 op1: OP_COPPER, op2: OP_COPPER,
                                 spd1: SPD_10, spd2: SPD_10, default: '0};

    state_t      s, n;
    logic [4:0]  av;
    logic        mii, pcs, dig, ana, ext, rev, near;
    logic        gen_en, chk_en, cont, gen_v, gen_adv, acc, start, clr;
    logic [22:0] g8, c8;
    stream_t     tx_src, rx_path, line_path;
    logic        fi_ready, fo_valid, fo_ready;
    logic [7:0]  fo_data;

    // ****************************************
    // Helpers
    // ****************************************
    // Eight steps of x^15 + x^14 + 1; returns new state and the byte, LSB first.
    function automatic logic [22:0] prbs8(input logic [14:0] st);
        logic [14:0] h;
        logic [7:0]  b;
        h = st;
        b = '0;
        for (int i = 0; i < 8; i++) begin
            b[i] = h[14] ^ h[13];
            h    = {h[13:0], b[i]};
        end
        return {h, b};
    endfunction : prbs8

    function automatic logic [14:0] shift_in(input logic [14:0] st,
                                             input logic [7:0]  b);
        logic [14:0] h;
        h = st;
        for (int i = 0; i < 8; i++) begin
            h = {h[13:0], b[i]};
        end
        return h;
    endfunction : shift_in

    function automatic logic [31:0] bump(input logic [31:0] v,
                                         input logic [31:0] max,
                                         input logic        wrap);
        if (v == max) begin
            return wrap ? '0 : v;
        end
        return v + 32'h1;
    endfunction : bump

    // Availability bits, in order MII, PCS, digital, analog, external.
    function automatic logic [4:0] loop_avail(input op_mode_t op, input speed_t sp);
        logic [4:0] a;
        a = 5'h1f;
        if (op == OP_COPPER) begin
            if (sp == SPD_10) a[1] = 1'b0;
            if (sp == SPD_1000) a[4] = 1'b0;
        end else if (op == OP_FIBER) begin
            if (sp == SPD_100) a[1:0] = 2'b00;
            a[4:3] = 2'b00;
        end else if (op == OP_S2R) begin
            a[4:1] = 4'h0;
        end else if (op == OP_R2S) begin
            a[4] = 1'b0;
            a[1] = 1'b0;
        end else begin
            if (sp != SPD_10) a[0] = 1'b0;
            if (sp != SPD_10) a[4] = 1'b0;
        end
        return a;
    endfunction : loop_avail

    // ****************************************
    // Loopback selection
    // ****************************************
    assign av   = loop_avail(s.op2, s.spd2);
    assign mii  = s.bc[BC_MII_LOOP] & av[0];
    assign pcs  = s.st[ST_PCS] & av[1] & ~mii;
    assign dig  = s.st[ST_DIG] & av[2] & ~mii & ~pcs;
    assign ana  = s.st[ST_ANA] & av[3] & ~mii & ~pcs & ~dig;
    assign ext  = s.st[ST_EXT] & av[4];
    assign near = mii | pcs | dig | ana;
    assign rev  = s.st[ST_REV] & ~near;

    assign gen_en = s.st[ST_GEN];
    assign chk_en = s.st[ST_CHK];
    assign cont   = s.st[ST_CONT];
    assign g8     = prbs8(s.glfsr);
    assign c8     = prbs8(s.hist);
    assign gen_v  = gen_en & (s.gst == GEN_PKT);
    assign gen_adv = gen_v & (~near | fi_ready);

    always_comb begin
        tx_src = mac_tx;
        if (gen_en) begin
            tx_src = '{valid: gen_v, data: g8[7:0]};
        end else if (rev) begin
            tx_src = '0;
        end
        line_path = tx_src;
        rx_path   = line_rx;
        if (mii) begin
            rx_path   = mac_tx;
            line_path = s.st[ST_MII_TX] ? mac_tx : '0;
        end else if (pcs | dig | ana) begin
            rx_path   = tx_src;
            line_path = '0;
        end else if (rev) begin
            line_path = line_rx;
            rx_path   = s.st[ST_REV_FWD] ? line_rx : '0;
        end
    end

    assign acc   = chk_en & rx_path.valid & fi_ready;
    assign start = chk_en & ~s.chk_d;
    assign clr   = start | (reg_req.wr & reg_req.addr == A_CERR & reg_req.wdata[CE_CLEAR]);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = s;
        n.op1  = op_mode;
        n.op2  = s.op1;
        n.spd1 = speed;
        n.spd2 = s.spd1;
        n.lnk1 = line_link;
        n.lnk2 = s.lnk1;

        // Packet generator.
        case (s.gst)
            GEN_IDLE: begin
                if (gen_en) begin
                    n.gst   = GEN_PKT;
                    n.gcnt  = s.pcfg[15:8];
                    n.glfsr = PRBS_SEED;
                end
            end
            GEN_PKT: begin
                if (!gen_en) begin
                    n.gst = GEN_IDLE;
                end else if (gen_adv) begin
                    n.glfsr = g8[22:8];
                    if (s.gcnt == '0) begin
                        n.gst  = GEN_GAP;
                        n.gcnt = s.pcfg[7:0];
                    end else begin
                        n.gcnt = s.gcnt - 8'h1;
                    end
                end
            end
            GEN_GAP: begin
                if (!gen_en) begin
                    n.gst = GEN_IDLE;
                end else if (s.gcnt == '0) begin
                    n.gst  = GEN_PKT;
                    n.gcnt = s.pcfg[15:8];
                end else begin
                    n.gcnt = s.gcnt - 8'h1;
                end
            end
            default: n.gst = GEN_IDLE;
        endcase

        // Checker; clears come first so a same-cycle event still counts.
        n.chk_d = chk_en;
        if (clr) begin
            n.err   = '0;
            n.bytes = '0;
            n.pkts  = '0;
        end
        if (start) begin
            n.locked = 1'b0;
            n.lost   = 1'b0;
            n.run    = '0;
        end
        if (acc) begin
            n.hist   = shift_in(s.hist, rx_path.data);
            n.prev_v = 1'b1;
            n.bytes  = 16'(bump(32'(n.bytes), 32'hffff, cont));
            if (!s.locked) begin
                if (c8[7:0] != rx_path.data) begin
                    n.run = '0;
                end else if (s.run == LOCK_RUN) begin
                    n.locked = 1'b1;
                    n.run    = '0;
                end else begin
                    n.run = s.run + 2'h1;
                end
            end else if (c8[7:0] != rx_path.data) begin
                n.err = 8'(bump(32'(n.err), 32'hff, cont));
                if (s.run == LOST_RUN) begin
                    n.locked = 1'b0;
                    n.lost   = 1'b1;
                    n.run    = '0;
                end else begin
                    n.run = s.run + 2'h1;
                end
            end else begin
                n.run = '0;
            end
        end else if (chk_en & ~rx_path.valid) begin
            n.prev_v = 1'b0;
            if (s.prev_v) begin
                n.pkts = bump(n.pkts, 32'hffffffff, cont);
            end
        end

        // Register writes.
        if (reg_req.wr) begin
            if (reg_req.addr == A_BASIC) begin
                n.bc = reg_req.wdata;
            end else if (reg_req.addr == A_PHY) begin
                n.phy = reg_req.wdata;
            end else if (reg_req.addr == A_ST) begin
                n.st = reg_req.wdata;
            end else if (reg_req.addr == A_PCFG) begin
                n.pcfg = reg_req.wdata;
            end else if (reg_req.addr == A_LSETUP) begin
                n.lsetup = reg_req.wdata;
            end else if (reg_req.addr == A_LERR && reg_req.wdata == LATCH_CMD) begin
                n.l_bytes = s.bytes;
                n.l_err   = s.err;
                n.l_pkts  = s.pkts;
            end
        end

        // Register reads, answered one cycle later.
        n.rvalid = reg_req.rd;
        n.rdata  = '0;
        if (reg_req.addr == A_BASIC) begin
            n.rdata = s.bc;
        end else if (reg_req.addr == A_PHY) begin
            n.rdata = s.phy;
        end else if (reg_req.addr == A_ST) begin
            n.rdata = s.st;
        end else if (reg_req.addr == A_GSTAT) begin
            n.rdata[GS_LOCK] = s.locked;
            n.rdata[GS_LOST] = s.lost;
            n.rdata[GS_BUSY] = s.gst != GEN_IDLE;
        end else if (reg_req.addr == A_CERR) begin
            n.rdata[7:0] = s.err;
        end else if (reg_req.addr == A_CBYTE) begin
            n.rdata = s.bytes;
        end else if (reg_req.addr == A_PCFG) begin
            n.rdata = s.pcfg;
        end else if (reg_req.addr == A_LBYTE) begin
            n.rdata = s.l_bytes;
        end else if (reg_req.addr == A_LERR) begin
            n.rdata[7:0] = s.l_err;
        end else if (reg_req.addr == A_LSETUP) begin
            n.rdata = s.lsetup;
        end else if (reg_req.addr == A_PKT_LO) begin
            n.rdata = s.l_pkts[15:0];
        end else if (reg_req.addr == A_PKT_HI) begin
            n.rdata = s.l_pkts[31:16];
        end
        if (!reg_req.rd) begin
            n.rdata = s.rdata;
        end

        // Output stages.
        n.ltx = line_path;
        if (fo_ready) begin
            n.mrx = '{valid: fo_valid, data: fo_data};
        end
        n.link = s.lnk2 | near;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= S_RST;
        end else begin
            s <= n;
        end
    end

    assign fo_ready = ~s.mrx.valid | mac_rx_ready;

    byte_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk       (core_clk),
        .arst_n    (arst_n),
        .in_valid  (rx_path.valid),
        .in_data   (rx_path.data),
        .in_ready  (fi_ready),
        .out_valid (fo_valid),
        .out_data  (fo_data),
        .out_ready (fo_ready)
    );

    assign mac_tx_ready  = fi_ready;
    assign line_rx_ready = fi_ready;
    assign mac_rx        = s.mrx;
    assign line_tx       = s.ltx;
    assign link_up       = s.link;
    assign reg_rdata     = s.rdata;
    assign reg_rvalid    = s.rvalid;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_rev_echo_line: assert property (rev |=> line_tx == $past(line_rx))
        else $error("reverse loop did not echo line data");
    a_mii_no_media: assert property (mii && !s.st[ST_MII_TX] |=> !line_tx.valid)
        else $error("MII loop leaked data onto media");
    a_bridge_no_pcs: assert property (s.op2 == OP_S2R |-> !(pcs | dig | ana | ext))
        else $error("loop allowed in bridge mode");
    a_ext_no_gig: assert property (s.spd2 == SPD_1000 |-> !ext)
        else $error("external loop allowed at gigabit");
    a_lock_after_run: assert property ($rose(s.locked) |-> $past(s.run) == LOCK_RUN)
        else $error("lock rose without matching run");
    a_err_saturate: assert property (!cont && s.err == 8'hff && !clr |=> s.err == 8'hff)
        else $error("error count left its maximum");
    a_err_wrap: assert property (cont && s.err == 8'hff && !clr && acc && s.locked
                                 && c8[7:0] != rx_path.data |=> s.err == 8'h00)
        else $error("error count did not wrap");
    a_snap_bytes: assert property (reg_req.wr && reg_req.addr == A_LERR
                                   && reg_req.wdata == LATCH_CMD |=> s.l_bytes == $past(s.bytes))
        else $error("snapshot did not catch byte count");
    a_byte_count: assert property (acc && !clr && s.bytes != 16'hffff
                                   |=> s.bytes == $past(s.bytes) + 16'h1)
        else $error("accepted byte not counted");
    a_lock_readback: assert property (reg_req.rd && reg_req.addr == A_GSTAT
                                      |=> reg_rvalid && reg_rdata[GS_LOCK] == $past(s.locked))
        else $error("lock bit read back wrong");

    c_locked: cover property ($rose(s.locked));
    c_sync_lost: cover property ($rose(s.lost));
    c_fifo_full: cover property (!fi_ready ##1 fi_ready);
    c_gen_gap: cover property (s.gst == GEN_PKT ##1 s.gst == GEN_GAP);
endmodule : selftest_top

`default_nettype wire

// *** shared/selftest_pkg.sv ***
// Constants, types and register map of the loopback and PRBS self-test block.
// Assumes a management port on the local reference clock of 100 MHz.
`default_nettype none
package selftest_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [8:0] A_BASIC  = 9'h000;
    localparam logic [8:0] A_PHY    = 9'h010;
    localparam logic [8:0] A_ST     = 9'h016;
    localparam logic [8:0] A_GSTAT  = 9'h017;
    localparam logic [8:0] A_CERR   = 9'h039;
    localparam logic [8:0] A_CBYTE  = 9'h03a;
    localparam logic [8:0] A_PCFG   = 9'h03b;
    localparam logic [8:0] A_LBYTE  = 9'h071;
    localparam logic [8:0] A_LERR   = 9'h072;
    localparam logic [8:0] A_LSETUP = 9'h0fe;
    localparam logic [8:0] A_PKT_LO = 9'h1a8;
    localparam logic [8:0] A_PKT_HI = 9'h1a9;
    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int BC_MII_LOOP = 14;
    localparam int ST_PCS      = 0;
    localparam int ST_EXT      = 1;
    localparam int ST_DIG      = 2;
    localparam int ST_ANA      = 3;
    localparam int ST_REV      = 4;
    localparam int ST_REV_FWD  = 5;
    localparam int ST_MII_TX   = 6;
    localparam int ST_CONT     = 13;
    localparam int ST_GEN      = 14;
    localparam int ST_CHK      = 15;
    localparam int GS_LOCK     = 11;
    localparam int GS_LOST     = 10;
    localparam int GS_BUSY     = 9;
    localparam int CE_CLEAR    = 8;
    localparam logic [15:0] LATCH_CMD = 16'h0201;
    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [15:0] RST_CTRL  = 16'h0000;
    localparam logic [15:0] RST_PCFG  = 16'h3f0b;
    localparam logic [14:0] PRBS_SEED = 15'h7fff;
    localparam logic [1:0]  LOCK_RUN  = 2'h3;
    localparam logic [1:0]  LOST_RUN  = 2'h3;
    localparam int          FIFO_W    = 8;
    localparam int          FIFO_D    = 8;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        OP_COPPER, OP_FIBER, OP_S2R, OP_R2S, OP_MCONV
    } op_mode_t;
    typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_t;
    typedef enum logic [2:0] {
        GEN_IDLE = 3'b001, GEN_PKT = 3'b010, GEN_GAP = 3'b100
    } gen_state_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } stream_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [8:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;
endpackage : selftest_pkg
`default_nettype wire

// *** sim/far_side.sv ***
// Far-side model: MAC receive sink and link partner byte source.
// Assumes core_clk and the stream type of selftest_pkg.
`timescale 1ns/10ps
`default_nettype none
module far_side (
    input  wire logic                  clk,
    input  wire logic                  stall,
    input  wire selftest_pkg::stream_t line_tx,
    input  wire logic                  line_rx_ready,
    input  wire selftest_pkg::stream_t mac_rx,
    output selftest_pkg::stream_t      line_rx,
    output logic                       mac_rx_ready
);
    import selftest_pkg::*;
    logic [7:0] mac_q[$];
    logic [7:0] line_q[$];
    initial line_rx = '0;
    assign mac_rx_ready = !stall;
    // ****
    // Capture of everything the block hands out.
    // ****
    always @(posedge clk) begin
        if (mac_rx.valid && mac_rx_ready)
            mac_q.push_back(mac_rx.data);
        if (line_tx.valid)
            line_q.push_back(line_tx.data);
    end
    // Idle data shows the inverse of the last byte, not a stale copy.
    // The ok flag tells the caller whether the block took the byte in time.
    task automatic send(input logic [7:0] b, output logic ok);
        @(negedge clk);
        line_rx <= '{1'b1, b};
        for (int k = 0; k < 20 && line_rx_ready !== 1'b1; k++)
            @(negedge clk);
        ok = line_rx_ready === 1'b1;
        @(negedge clk);
        line_rx <= '{1'b0, ~b};
    endtask : send
endmodule : far_side
`default_nettype wire

// *** sim/selftest_top_bench.sv ***
// Bench of the loopback and self-test block: register tasks and scenarios.
// Assumes selftest_pkg and far_side are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module selftest_top_bench;
    import selftest_pkg::*;
    logic        core_clk, arst_n, line_link, stall;
    op_mode_t    op_mode;
    speed_t      speed;
    stream_t     mac_tx, mac_rx, line_rx, line_tx;
    reg_req_t    reg_req;
    logic        mac_tx_ready, mac_rx_ready, line_rx_ready, link_up, reg_rvalid;
    logic [15:0] reg_rdata, v;
    logic [7:0]  n;
    logic        ok;
    int          err_total, n_checks, i;
    selftest_top dut (
        .core_clk(core_clk), .arst_n(arst_n), .op_mode(op_mode), .speed(speed),
        .line_link(line_link), .mac_tx(mac_tx), .mac_tx_ready(mac_tx_ready),
        .mac_rx(mac_rx), .mac_rx_ready(mac_rx_ready), .line_rx(line_rx),
        .line_rx_ready(line_rx_ready), .line_tx(line_tx), .link_up(link_up),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
    );
    far_side p (
        .clk(core_clk), .stall(stall), .line_tx(line_tx), .line_rx_ready(line_rx_ready),
        .mac_rx(mac_rx), .line_rx(line_rx), .mac_rx_ready(mac_rx_ready)
    );
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ****
    // Register port, MAC transmit, MAC receive wait and finish tasks
    // ****
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(negedge core_clk);
        reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(negedge core_clk);
        reg_req <= '{1'b0, 1'b1, a, 16'h0000};
        @(negedge core_clk);
        `CHK("rvalid", 1'b1, reg_rvalid)
        d = reg_rdata;
        reg_req <= '0;
    endtask : rd
    task automatic tx(input logic [7:0] b);
        @(negedge core_clk);
        mac_tx <= '{1'b1, b};
        for (int k = 0; k < 20 && mac_tx_ready !== 1'b1; k++)
            @(negedge core_clk);
        `CHK("tx ready", 1'b1, mac_tx_ready)
        @(negedge core_clk);
        mac_tx <= '{1'b0, ~b};
    endtask : tx
    task automatic wm(input int k);
        for (int j = 0; j < 30 && p.mac_q.size() < k; j++)
            @(negedge core_clk);
        `CHK("wait", 1'b1, p.mac_q.size() >= k)
    endtask : wm
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // ****
    // Scenarios
    // ****
    initial begin
        reg_req = '0; mac_tx = '0; stall = 1'b0; line_link = 1'b0; arst_n = 1'b0;
        op_mode = OP_COPPER;
        speed = SPD_1000;
        repeat (6) @(negedge core_clk);
        arst_n = 1'b1;
        rd(A_PCFG, v); `CHK("pcfg", 16'h3f0b, v)
        `CHK("link idle", 1'b0, link_up)
        wr(A_GSTAT, 16'hffff);
        rd(A_GSTAT, v); `CHK("gstat", 16'h0000, v)
        rd(9'h1ff, v); `CHK("unmapped", 16'h0000, v)
        wr(A_LSETUP, 16'he720);
        rd(A_LSETUP, v); `CHK("lsetup", 16'he720, v)
        wr(A_BASIC, 16'h0140);
        wr(A_PHY, 16'h5028);
        wr(A_ST, 16'h0004);
        rd(A_PHY, v); `CHK("phy", 16'h5028, v)
        `CHK("link", 1'b1, link_up)
        stall = 1'b1;
        n = 8'h00;
        for (i = 0; i < 20; i++) begin
            @(negedge core_clk);
            mac_tx <= '{mac_tx_ready === 1'b1, mac_tx_ready === 1'b1 ? n : ~n};
            if (mac_tx_ready === 1'b1)
                n++;
        end
        `CHK("fill", 1'b1, n == 8'h08 || n == 8'h09)
        stall = 1'b0;
        wm(n);
        for (i = 0; i < n; i++)
            `CHK("order", i[7:0], p.mac_q[i])
        `CHK("ready", 1'b1, mac_tx_ready)
        wr(A_BASIC, 16'h4000);
        wr(A_ST, 16'h0044);
        p.mac_q.delete(); p.line_q.delete();
        tx(8'h5a); wm(1);
        `CHK("mii mac", 8'h5a, p.mac_q[0])
        `CHK("mii line", 8'h5a, p.line_q[0])
        wr(A_BASIC, 16'h0000);
        wr(A_ST, 16'h0010);
        line_link = 1'b1;
        p.mac_q.delete();
        p.line_q.delete();
        tx(8'hc3);
        p.send(8'h3c, ok);
        repeat (3) @(negedge core_clk);
        `CHK("send", 1'b1, ok)
        `CHK("rev line", 8'h3c, p.line_q[0])
        `CHK("rev count", 1'b1, p.line_q.size() == 1 && p.mac_q.size() == 0)
        `CHK("link line", 1'b1, link_up)
        wr(A_ST, 16'h0030);
        p.send(8'h69, ok);
        wm(1);
        `CHK("send fwd", 1'b1, ok)
        `CHK("rev fwd", 8'h69, p.mac_q[0])
        wr(A_ST, 16'h0001);
        for (i = 0; i < 3; i++) begin
            op_mode = i == 1 ? OP_FIBER : OP_COPPER;
            speed = i == 2 ? SPD_10 : SPD_100;
            repeat (4) @(negedge core_clk);
            p.mac_q.delete();
            tx(8'h11);
            if (i == 0) begin
                wm(1);
            end else begin
                repeat (6) @(negedge core_clk);
            end
            `CHK("pcs", i == 0, p.mac_q.size() == 1)
        end
        op_mode = OP_COPPER;
        speed = SPD_1000;
        wr(A_ST, 16'h0008);
        p.mac_q.delete();
        tx(8'h77);
        wm(1);
        `CHK("analog", 8'h77, p.mac_q[0])
        wr(A_ST, 16'hf004);
        v = 16'h0000;
        for (i = 0; i < 40 && v[GS_LOCK] !== 1'b1; i++)
            rd(A_GSTAT, v);
        `CHK("lock", 1'b1, v[GS_LOCK])
        `CHK("busy lost", 2'b10, {v[GS_BUSY], v[GS_LOST]})
        rd(A_CERR, v); `CHK("errors", 8'h00, v[7:0])
        rd(A_CBYTE, v); `CHK("bytes", 1'b1, v != 16'h0000)
        repeat (150) @(negedge core_clk);
        wr(A_LERR, LATCH_CMD);
        rd(A_LERR, v); `CHK("latched err", 8'h00, v[7:0])
        rd(A_LBYTE, v); `CHK("latched bytes", 1'b1, v != 16'h0000)
        rd(A_PKT_LO, v); `CHK("packets lo", 1'b1, v != 16'h0000)
        rd(A_PKT_HI, v); `CHK("packets hi", 16'h0000, v)
        finish_test();
    end
endmodule : selftest_top_bench
`undef CHK
`default_nettype wire
